// ==== core/lp_cfg.svh ====
// Timing figures, mode register map and field layout for the power-down link.
`ifndef LP_CFG_SVH
`define LP_CFG_SVH

// Core clock period in picoseconds (100 MHz)
`define LP_CLK_PS 10000

// Clock-enable pulse width, both levels
`define LP_TCKE_PS 7500
`define LP_TCKE_NCK 4
// Last command to clock-enable low
`define LP_TCMDCKE_PS 1750
`define LP_TCMDCKE_NCK 3
// Clock and select kept valid after clock-enable low
`define LP_TCKELCK_PS 5000
`define LP_TCKELCK_NCK 5
// Select valid before clock-enable low
`define LP_TCSCKE_PS 1750
// Clock running before clock-enable high
`define LP_TCKCKEH_PS 1750
`define LP_TCKCKEH_NCK 3
// Power-down exit to next command
`define LP_TXP_PS 7500
`define LP_TXP_NCK 5
// Select valid before and after clock-enable high
`define LP_TCSCKEH_PS 1750
`define LP_TCKEHCS_PS 7500
// Clock and select after clock-enable low following a mode write
`define LP_TMRWCKEL_PS 14000
`define LP_TMRWCKEL_NCK 10
// Clock and select after clock-enable low following calibration start
`define LP_TZQCKE_PS 1750
`define LP_TZQCKE_NCK 3
// Mode write period, mode set delay, mode read period
`define LP_TMRW_PS 10000
`define LP_TMRW_NCK 10
`define LP_TMRD_PS 14000
`define LP_TMRD_NCK 10
`define LP_TMRR_NCK 8
// Row-to-column delay and the extra margin before a mode read
`define LP_TRCD_PS 18000
`define LP_TRCD_NCK 4
`define LP_TMRRI_NCK 3
// Strobe output delay limit and the delay actually used
`define LP_TSDO_PS 20000
`define LP_TSDO_NCK 12
`define LP_SDO_DLY_NCK 2
// Boot clock period limits and the divider that meets them
`define LP_TCKB_MIN_PS 18000
`define LP_TCKB_MAX_PS 100000
`define LP_BOOT_DIV 4

// Event timers
`define LP_NEV 8
`define LP_CNT_W 8
`define LP_EV_CMD 0
`define LP_EV_CKE_UP 1
`define LP_EV_CKE_DN 2
`define LP_EV_MRW 3
`define LP_EV_MRR 4
`define LP_EV_ZQ 5
`define LP_EV_CKON 6
`define LP_EV_CSON 7

// Mode register map and fields
`define LP_MA_W 6
`define LP_OP_W 8
`define LP_MR_NUM 64
`define LP_MR_RST 8'h00
`define LP_MA_LAT 6'h02
`define LP_MA_DBI 6'h03
`define LP_MA_RATE 6'h04
`define LP_MA_DQS 6'h0F
`define LP_RL_IDX_LSB 0
`define LP_WL_IDX_LSB 3
`define LP_WL_SET_BIT 6
`define LP_DBI_RD_BIT 6
`define LP_RATE_W 3
`define LP_DQS_REQ_BIT 0
`define LP_LAT_W 6
`define LP_RL_MAX 40

`endif

// ==== core/lp_pkg.sv ====
// Types and latency lookups shared by both ends of the power-down link.
`include "lp_cfg.svh"
package lp_pkg;
  // Commands carried on the link
  typedef enum logic [2:0] {
    LP_CMD_NOP = 3'h0,
    LP_CMD_MRW = 3'h1,
    LP_CMD_MRR = 3'h2,
    LP_CMD_ZQS = 3'h3,
    LP_CMD_OTHER = 3'h4
  } lp_cmd_t;

  // Power-down sequence, Gray coded along the loop
  typedef enum logic [1:0] {
    LP_ST_ACTIVE = 2'h0,
    LP_ST_ENTER = 2'h1,
    LP_ST_CLKOFF = 2'h3,
    LP_ST_CLKON = 2'h2
  } lp_pd_st_t;

  // Least time in core cycles, rounded up, never below one
  function automatic int lp_cyc(input int ps);
    int c;
    c = (ps + `LP_CLK_PS - 1) / `LP_CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Write latency per data-rate index, set A or set B
  function automatic logic [`LP_LAT_W-1:0] lp_wl(input logic [2:0] idx, input logic set_b);
    logic [`LP_LAT_W-1:0] a;
    logic [`LP_LAT_W-1:0] b;
    case (idx)
      3'h0: begin a = 6'h04; b = 6'h04; end
      3'h1: begin a = 6'h06; b = 6'h08; end
      3'h2: begin a = 6'h08; b = 6'h0C; end
      3'h3: begin a = 6'h0A; b = 6'h12; end
      3'h4: begin a = 6'h0C; b = 6'h16; end
      3'h5: begin a = 6'h0E; b = 6'h1A; end
      3'h6: begin a = 6'h10; b = 6'h1E; end
      default: begin a = 6'h12; b = 6'h22; end
    endcase
    return set_b ? b : a;
  endfunction

  // Read latency per data-rate index, inversion off or on
  function automatic logic [`LP_LAT_W-1:0] lp_rl(input logic [2:0] idx, input logic dbi);
    logic [`LP_LAT_W-1:0] a;
    logic [`LP_LAT_W-1:0] b;
    case (idx)
      3'h0: begin a = 6'h06; b = 6'h06; end
      3'h1: begin a = 6'h0A; b = 6'h0C; end
      3'h2: begin a = 6'h0E; b = 6'h10; end
      3'h3: begin a = 6'h14; b = 6'h16; end
      3'h4: begin a = 6'h18; b = 6'h1C; end
      3'h5: begin a = 6'h1C; b = 6'h20; end
      3'h6: begin a = 6'h20; b = 6'h24; end
      default: begin a = 6'h24; b = 6'h28; end
    endcase
    return dbi ? b : a;
  endfunction
endpackage

// ==== core/lp_link_if.sv ====
// Link between the memory controller end and the memory device end.
`timescale 1ns/10ps
`include "lp_cfg.svh"
interface lp_link_if;
  logic ck_tick; // One device clock edge; high only while the clock runs
  logic cke; // Clock-enable level
  logic cs; // Chip select, high with a command
  logic cs_drv; // Select is driven to a valid level
  lp_pkg::lp_cmd_t cmd; // Command code
  logic [`LP_MA_W-1:0] ma; // Mode register address
  logic [`LP_OP_W-1:0] op; // Mode register operand
  logic [`LP_OP_W-1:0] dq; // Read-back data from the device
  logic dq_oe; // Device drives read-back data
  logic dqs; // Data strobe level
  logic dqs_oe; // Device drives the strobe

  modport ctrl (output ck_tick, cke, cs, cs_drv, cmd, ma, op, input dq, dq_oe, dqs, dqs_oe);
  modport dev (input ck_tick, cke, cs, cs_drv, cmd, ma, op, output dq, dq_oe, dqs, dqs_oe);
endinterface

// ==== core/lp_dev_end.sv ====
// Device end: mode registers, latency selection, read-back and strobe output.
`timescale 1ns/10ps
`include "lp_cfg.svh"
module lp_dev_end #(
  parameter int MR_NUM = `LP_MR_NUM,
  parameter int RL_MAX = `LP_RL_MAX
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [`LP_RATE_W-1:0] i_temp_rate,
  output logic [`LP_LAT_W-1:0] o_wl,
  output logic [`LP_LAT_W-1:0] o_rl,
  output logic [`LP_RATE_W-1:0] o_refresh_rate,
  output logic o_pd,
  lp_link_if.dev link
);
  logic take; // Command accepted on this device clock edge
  logic mrw; // Mode write taken
  logic mrr; // Mode read taken
  logic [`LP_OP_W-1:0] mr_r [MR_NUM]; // Mode register file
  logic pv_r [RL_MAX]; // Read-back pipeline valid per stage
  logic [`LP_OP_W-1:0] pd_r [RL_MAX]; // Read-back pipeline data per stage
  logic [`LP_LAT_W-1:0] wl_r; // Selected write latency
  logic [`LP_LAT_W-1:0] rl_r; // Selected read latency
  logic [`LP_OP_W-1:0] dq_r; // Read-back data out
  logic dq_oe_r; // Read-back data valid
  logic dqs_en_r; // Strobe output requested
  logic [3:0] dqs_wait_r; // Ticks left before the strobe starts
  logic dqs_r; // Strobe level
  logic dqs_oe_r; // Strobe driven
  logic pd_r_st; // Power-down status

  // Commands count only on a clock edge with clock-enable high and select asserted
  assign take = link.ck_tick && link.cke && link.cs;
  assign mrw = take && (link.cmd == lp_pkg::LP_CMD_MRW);
  assign mrr = take && (link.cmd == lp_pkg::LP_CMD_MRR);

  // One register per mode address; the refresh-rate field follows the sensor
  genvar g;
  for (g = 0; g < MR_NUM; g++)
  begin : g_mr
    always_ff @(posedge i_mclk)
    begin
      if (i_rst)
        mr_r[g] <= `LP_MR_RST;
      else if (g == int'(`LP_MA_RATE))
      begin
        // Sensor owns the low field; software may write only the upper bits
        if (mrw && (link.ma == `LP_MA_RATE))
          mr_r[g] <= {link.op[`LP_OP_W-1:`LP_RATE_W], i_temp_rate};
        else
          mr_r[g] <= {mr_r[g][`LP_OP_W-1:`LP_RATE_W], i_temp_rate};
      end
      else if (mrw && (int'(link.ma) == g))
        mr_r[g] <= link.op;
    end
  end

  // Latencies come from the frequency-set register, its set bit and the read-inversion bit of the DBI register
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      wl_r <= lp_pkg::lp_wl(3'h0, 1'b0);
      rl_r <= lp_pkg::lp_rl(3'h0, 1'b0);
    end
    else
    begin
      wl_r <= lp_pkg::lp_wl(mr_r[`LP_MA_LAT][`LP_WL_IDX_LSB +: 3],
                            mr_r[`LP_MA_LAT][`LP_WL_SET_BIT]);
      rl_r <= lp_pkg::lp_rl(mr_r[`LP_MA_LAT][`LP_RL_IDX_LSB +: 3],
                            mr_r[`LP_MA_DBI][`LP_DBI_RD_BIT]);
    end
  end

  // Read-back pipeline shifts once per device clock; several reads may be in flight
  for (g = 0; g < RL_MAX; g++)
  begin : g_pipe
    always_ff @(posedge i_mclk)
    begin
      if (i_rst)
      begin
        pv_r[g] <= 1'b0;
        pd_r[g] <= '0;
      end
      else if (link.ck_tick)
      begin
        if (g == 0)
        begin
          pv_r[g] <= mrr;
          pd_r[g] <= mr_r[link.ma];
        end
        else
        begin
          pv_r[g] <= pv_r[g-1];
          pd_r[g] <= pd_r[g-1];
        end
      end
    end
  end

  // Data leaves one core cycle after the read-latency-th clock edge
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      dq_r <= '0;
      dq_oe_r <= 1'b0;
    end
    else
    begin
      dq_oe_r <= link.ck_tick && pv_r[int'(rl_r) - 1];
      if (link.ck_tick && pv_r[int'(rl_r) - 1])
        dq_r <= pd_r[int'(rl_r) - 1];
    end
  end

  // Strobe starts a fixed few clocks after the request, well inside the limit
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      dqs_en_r <= 1'b0;
      dqs_wait_r <= '0;
      dqs_r <= 1'b0;
      dqs_oe_r <= 1'b0;
    end
    else if (mrw && (link.ma == `LP_MA_DQS))
    begin
      dqs_en_r <= link.op[`LP_DQS_REQ_BIT];
      dqs_wait_r <= 4'(`LP_SDO_DLY_NCK);
      dqs_oe_r <= 1'b0;
      dqs_r <= 1'b0;
    end
    else if (dqs_en_r && link.ck_tick)
    begin
      if (dqs_wait_r > 4'h1)
        dqs_wait_r <= dqs_wait_r - 4'h1;
      else
      begin
        // Drive and toggle once per clock from here on
        dqs_wait_r <= 4'h0;
        dqs_oe_r <= 1'b1;
        dqs_r <= dqs_oe_r ? ~dqs_r : 1'b0;
      end
    end
  end

  // Power-down shows whenever clock-enable is low
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      pd_r_st <= 1'b1;
    else
      pd_r_st <= !link.cke;
  end

  assign link.dq = dq_r;
  assign link.dq_oe = dq_oe_r;
  assign link.dqs = dqs_r;
  assign link.dqs_oe = dqs_oe_r;
  assign o_wl = wl_r;
  assign o_rl = rl_r;
  assign o_refresh_rate = mr_r[`LP_MA_RATE][`LP_RATE_W-1:0];
  assign o_pd = pd_r_st;
endmodule

// ==== core/lp_ctrl_end.sv ====
// Controller end: issues commands and sequences clock-enable, clock and select.
`timescale 1ns/10ps
`include "lp_cfg.svh"
module lp_ctrl_end #(
  parameter int BOOT_DIV = `LP_BOOT_DIV,
  parameter int CNT_W = `LP_CNT_W
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_boot,
  input wire logic i_pd_req,
  input wire logic i_req_valid,
  input wire lp_pkg::lp_cmd_t i_req_cmd,
  input wire logic [`LP_MA_W-1:0] i_req_ma,
  input wire logic [`LP_OP_W-1:0] i_req_op,
  output logic o_req_ready,
  output logic o_pd_active,
  output logic o_rd_valid,
  output logic [`LP_OP_W-1:0] o_rd_data,
  lp_link_if.ctrl link
);
  // Waits in core cycles, each a least time rounded up
  localparam int CKE_NS = lp_pkg::lp_cyc(`LP_TCKE_PS);
  localparam int CMDCKE_NS = lp_pkg::lp_cyc(`LP_TCMDCKE_PS);
  localparam int CKELCK_NS = lp_pkg::lp_cyc(`LP_TCKELCK_PS);
  localparam int CSCKE_NS = lp_pkg::lp_cyc(`LP_TCSCKE_PS);
  localparam int CKCKEH_NS = lp_pkg::lp_cyc(`LP_TCKCKEH_PS);
  localparam int XP_NS = lp_pkg::lp_cyc(`LP_TXP_PS);
  localparam int CSCKEH_NS = lp_pkg::lp_cyc(`LP_TCSCKEH_PS);
  localparam int CKEHCS_NS = lp_pkg::lp_cyc(`LP_TCKEHCS_PS);
  localparam int MRWCKEL_NS = lp_pkg::lp_cyc(`LP_TMRWCKEL_PS);
  localparam int ZQCKE_NS = lp_pkg::lp_cyc(`LP_TZQCKE_PS);
  localparam int MRW_NS = lp_pkg::lp_cyc(`LP_TMRW_PS);
  localparam int MRD_NS = lp_pkg::lp_cyc(`LP_TMRD_PS);
  localparam int RCD_NS = lp_pkg::lp_cyc(`LP_TRCD_PS);
  // Mode read after exit: exit delay, then row-to-column delay plus margin
  localparam int MRRI_NS = XP_NS + RCD_NS;
  localparam int MRRI_NCK = `LP_TXP_NCK + `LP_TRCD_NCK + `LP_TMRRI_NCK;
  localparam int DIV_W = $clog2(BOOT_DIV + 1);

  lp_pkg::lp_pd_st_t st_r; // Power-down sequence state
  lp_pkg::lp_pd_st_t st_nxt; // Next state
  logic [DIV_W-1:0] div_r; // Boot clock divider phase
  logic div_ok; // Next cycle may carry a device clock edge
  logic tick_nxt; // Next cycle carries a device clock edge
  logic tick_r; // Device clock edge on the link
  logic cke_r; // Clock-enable out
  logic cke_q_r; // Clock-enable one cycle back, for edge detection
  logic ck_run_r; // Clock running
  logic ck_run_q_r; // Clock running one cycle back
  logic cs_drv_r; // Select driven to a valid level
  logic cs_drv_q_r; // Select driven one cycle back
  logic cs_r; // Select asserted with a command
  lp_pkg::lp_cmd_t cmd_r; // Command out
  logic [`LP_MA_W-1:0] ma_r; // Address out
  logic [`LP_OP_W-1:0] op_r; // Operand out
  logic issue; // Request taken this cycle
  logic cmd_ok; // Spacing for the offered command is met
  logic pd_active_r; // Power-down in progress
  logic rd_valid_r; // Read-back data valid
  logic [`LP_OP_W-1:0] rd_data_r; // Read-back data
  logic [`LP_NEV-1:0] ev; // Link events that restart the timers
  logic [CNT_W-1:0] ns_cnt_r [`LP_NEV]; // Core cycles since each event
  logic [CNT_W-1:0] nck_cnt_r [`LP_NEV]; // Device clocks since each event

  // A wait is over only once both the time and the clock count have passed;
  // nx counts the edge in the coming cycle, for actions taken on that edge.
  // An event showing now has not cleared its timer yet, so it is never met.
  function automatic logic met(input int i, input int ns, input int nck, input logic nx);
    met = !ev[i] && (int'(ns_cnt_r[i]) + 2 >= ns) &&
          (int'(nck_cnt_r[i]) + int'(tick_r) + int'(nx) >= nck);
  endfunction

  // Events are seen on the link itself so timers match what the device sees
  always_comb
  begin
    ev = '0;
    ev[`LP_EV_CMD] = tick_r && (cmd_r != lp_pkg::LP_CMD_NOP);
    ev[`LP_EV_CKE_UP] = cke_r && !cke_q_r;
    ev[`LP_EV_CKE_DN] = !cke_r && cke_q_r;
    ev[`LP_EV_MRW] = tick_r && (cmd_r == lp_pkg::LP_CMD_MRW);
    ev[`LP_EV_MRR] = tick_r && (cmd_r == lp_pkg::LP_CMD_MRR);
    ev[`LP_EV_ZQ] = tick_r && (cmd_r == lp_pkg::LP_CMD_ZQS);
    ev[`LP_EV_CKON] = ck_run_r && !ck_run_q_r;
    ev[`LP_EV_CSON] = cs_drv_r && !cs_drv_q_r;
  end

  // Saturating timers; they start saturated, but clock-on and select-on restart on the first cycle out of reset
  genvar g;
  for (g = 0; g < `LP_NEV; g++)
  begin : g_tmr
    always_ff @(posedge i_mclk)
    begin
      if (i_rst)
      begin
        ns_cnt_r[g] <= '1;
        nck_cnt_r[g] <= '1;
      end
      else if (ev[g])
      begin
        ns_cnt_r[g] <= '0;
        nck_cnt_r[g] <= '0;
      end
      else
      begin
        if (ns_cnt_r[g] != '1)
          ns_cnt_r[g] <= ns_cnt_r[g] + 1'b1;
        if (tick_r && (nck_cnt_r[g] != '1))
          nck_cnt_r[g] <= nck_cnt_r[g] + 1'b1;
      end
    end
  end

  // Boot mode slows the device clock to one edge per BOOT_DIV core cycles
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      div_r <= '0;
    else if (div_r >= DIV_W'(BOOT_DIV - 1))
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  // Default divider gives a 40 ns boot period, inside the allowed band
  assign div_ok = !i_boot || (div_r == '0);

  // Power-down sequence
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      lp_pkg::LP_ST_ACTIVE:
      begin
        // Enter whether or not a command is offered; the pending request keeps ready low so none is taken
        if (i_pd_req && div_ok &&
            met(`LP_EV_CKE_UP, CKE_NS, `LP_TCKE_NCK, 1'b1) &&
            met(`LP_EV_CMD, CMDCKE_NS, `LP_TCMDCKE_NCK, 1'b1) &&
            met(`LP_EV_CSON, CSCKE_NS, 1, 1'b1))
          st_nxt = lp_pkg::LP_ST_ENTER;
      end
      lp_pkg::LP_ST_ENTER:
      begin
        // Clock and select stay valid until every post-entry hold is over
        if (met(`LP_EV_CKE_DN, CKELCK_NS, `LP_TCKELCK_NCK, 1'b0) &&
            // Equal timers mean the mode write was the last command
            ((ns_cnt_r[`LP_EV_MRW] != ns_cnt_r[`LP_EV_CMD]) ||
             met(`LP_EV_CKE_DN, MRWCKEL_NS, `LP_TMRWCKEL_NCK, 1'b0)) &&
            met(`LP_EV_ZQ, ZQCKE_NS, `LP_TZQCKE_NCK, 1'b0))
          st_nxt = lp_pkg::LP_ST_CLKOFF;
      end
      lp_pkg::LP_ST_CLKOFF:
      begin
        if (!i_pd_req)
          st_nxt = lp_pkg::LP_ST_CLKON;
      end
      lp_pkg::LP_ST_CLKON:
      begin
        // Clock-enable rises only on a clock edge after all setup is met
        if (div_ok &&
            met(`LP_EV_CKON, CKCKEH_NS, `LP_TCKCKEH_NCK, 1'b0) &&
            met(`LP_EV_CSON, CSCKEH_NS, 1, 1'b1) &&
            met(`LP_EV_CKE_DN, CKE_NS, `LP_TCKE_NCK, 1'b1))
          st_nxt = lp_pkg::LP_ST_ACTIVE;
      end
      default:
        st_nxt = lp_pkg::LP_ST_CLKON;
    endcase
  end

  // Clock edges only while the clock runs
  assign tick_nxt = (st_nxt != lp_pkg::LP_ST_CLKOFF) && div_ok;

  // Command spacing for whatever is offered now
  always_comb
  begin
    cmd_ok = met(`LP_EV_CKE_UP, XP_NS, `LP_TXP_NCK, 1'b1) &&
             met(`LP_EV_MRW, MRD_NS, `LP_TMRD_NCK, 1'b1);
    if (i_req_cmd == lp_pkg::LP_CMD_MRW)
      cmd_ok = cmd_ok && met(`LP_EV_MRW, MRW_NS, `LP_TMRW_NCK, 1'b1);
    if (i_req_cmd == lp_pkg::LP_CMD_MRR)
    begin
      cmd_ok = cmd_ok && met(`LP_EV_MRR, 1, `LP_TMRR_NCK, 1'b1);
      cmd_ok = cmd_ok && met(`LP_EV_CKE_UP, MRRI_NS, MRRI_NCK, 1'b1);
    end
  end

  // A pending power-down request blocks new commands so the queue drains
  assign o_req_ready = (st_r == lp_pkg::LP_ST_ACTIVE) && !i_pd_req && div_ok && cmd_ok;
  assign issue = o_req_ready && i_req_valid;

  // State register; reset starts with the clock running and clock-enable low
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      st_r <= lp_pkg::LP_ST_CLKON;
    else
      st_r <= st_nxt;
  end

  // Clock-enable, clock and select levels follow the next state
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cke_r <= 1'b0;
      cke_q_r <= 1'b0;
      ck_run_r <= 1'b1;
      ck_run_q_r <= 1'b0;
      cs_drv_r <= 1'b1;
      cs_drv_q_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      cke_r <= (st_nxt == lp_pkg::LP_ST_ACTIVE);
      cke_q_r <= cke_r;
      ck_run_r <= (st_nxt != lp_pkg::LP_ST_CLKOFF);
      ck_run_q_r <= ck_run_r;
      // Select is released only with the clock, so it is valid around both edges
      cs_drv_r <= (st_nxt != lp_pkg::LP_ST_CLKOFF);
      cs_drv_q_r <= cs_drv_r;
      tick_r <= tick_nxt;
    end
  end

  // Command registers; a command lasts exactly one device clock edge
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cmd_r <= lp_pkg::LP_CMD_NOP;
      cs_r <= 1'b0;
      ma_r <= '0;
      op_r <= '0;
    end
    else
    begin
      cmd_r <= issue ? i_req_cmd : lp_pkg::LP_CMD_NOP;
      cs_r <= issue && (i_req_cmd != lp_pkg::LP_CMD_NOP);
      if (issue)
      begin
        ma_r <= i_req_ma;
        op_r <= i_req_op;
      end
    end
  end

  // Read-back capture and power-down status
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
      pd_active_r <= 1'b1;
    end
    else
    begin
      rd_valid_r <= link.dq_oe;
      if (link.dq_oe)
        rd_data_r <= link.dq;
      pd_active_r <= (st_nxt != lp_pkg::LP_ST_ACTIVE);
    end
  end

  assign link.ck_tick = tick_r;
  assign link.cke = cke_r;
  assign link.cs = cs_r;
  assign link.cs_drv = cs_drv_r;
  assign link.cmd = cmd_r;
  assign link.ma = ma_r;
  assign link.op = op_r;
  assign o_pd_active = pd_active_r;
  assign o_rd_valid = rd_valid_r;
  assign o_rd_data = rd_data_r;
endmodule

// ==== dv/lp_link_sva.sv ====
// Timing assertions on the link between controller end and device end.
`timescale 1ns/10ps
module lp_link_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic ck_tick,
  input wire logic cke,
  input wire logic cs,
  input wire logic cs_drv,
  input wire lp_pkg::lp_cmd_t cmd,
  input wire logic [5:0] ma,
  input wire logic [7:0] op,
  input wire logic dqs_oe
);
  logic cke_q; // Level seen one cycle earlier
  logic [7:0] lvl_nck; // Device edges at the present level, saturating
  logic [7:0] cmd_nck; // Device edges since the last command, its own included
  lp_pkg::lp_cmd_t last_cmd; // Kind of the last command

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // Counts device edges, not core cycles, so a slow clock is judged fairly
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      cke_q <= 1'b0;
      lvl_nck <= 8'hFF;
      cmd_nck <= 8'hFF;
      last_cmd <= lp_pkg::LP_CMD_NOP;
    end
    else
    begin
      cke_q <= cke;
      // A level change restarts the count with this cycle's edge
      if (cke != cke_q)
        lvl_nck <= {7'h00, ck_tick};
      else if (ck_tick && lvl_nck != 8'hFF)
        lvl_nck <= lvl_nck + 8'h01;
      if (cs)
      begin
        cmd_nck <= 8'h01;
        last_cmd <= cmd;
      end
      else if (ck_tick && cmd_nck != 8'hFF)
        cmd_nck <= cmd_nck + 8'h01;
    end
  end

  a_cke_width: assert property (cke != cke_q |-> lvl_nck >= 8'h04)
    else $error("clock-enable level held too briefly");
  a_cmd_to_low: assert property (cke_q && !cke |-> cmd_nck >= 8'h03)
    else $error("clock-enable dropped too soon after a command");
  a_clk_after_low: assert property (cke_q && !cke |-> (ck_tick && cs_drv)[*5])
    else $error("clock or select stopped too soon");
  a_mrw_clk_hold: assert property (cke_q && !cke && last_cmd == lp_pkg::LP_CMD_MRW |->
    (ck_tick && cs_drv)[*8] ##1 (ck_tick && cs_drv)[*2])
    else $error("clock stopped too soon after a mode write");
  a_cs_around_edge: assert property (cke != cke_q |-> $past(cs_drv) && cs_drv)
    else $error("select not valid around clock-enable edge");
  a_clk_before_high: assert property (!cke_q && cke |->
    $past(ck_tick, 1) && $past(ck_tick, 2) && $past(ck_tick, 3))
    else $error("clock not running before clock-enable rise");
  a_exit_to_cmd: assert property (cs |-> cke && lvl_nck >= 8'h05)
    else $error("command too soon after power-down exit");
  a_cs_after_high: assert property (!cke_q && cke |-> cs_drv[*2])
    else $error("select dropped after clock-enable rise");
  a_mode_set_gap: assert property (cs && last_cmd == lp_pkg::LP_CMD_MRW |->
    cmd_nck >= 8'h0A)
    else $error("command too soon after a mode write");
  a_read_gap: assert property (cs && cmd == lp_pkg::LP_CMD_MRR &&
    last_cmd == lp_pkg::LP_CMD_MRR |-> cmd_nck >= 8'h08)
    else $error("mode reads too close");
  a_read_after_exit: assert property (cs && cmd == lp_pkg::LP_CMD_MRR |->
    lvl_nck >= 8'h0C)
    else $error("mode read too soon after exit");
  a_strobe_start: assert property (cs && cmd == lp_pkg::LP_CMD_MRW && ma == 6'h0F && op[0] |->
    ##[1:12] dqs_oe)
    else $error("strobe not driven in time");

  c_mrw_pd: cover property (cke_q && !cke && last_cmd == lp_pkg::LP_CMD_MRW);
  c_read_pair: cover property (cs && cmd == lp_pkg::LP_CMD_MRR && last_cmd == lp_pkg::LP_CMD_MRR);
  c_pd_exit: cover property (!cke_q && cke);
endmodule

// ==== dv/lpddr_cke_mode_reg_timing_tb_top.sv ====
// Self-checking bench joining both ends of the power-down link.
`timescale 1ns/10ps
module lpddr_cke_mode_reg_timing_tb_top;
  localparam int BD = 4; // Boot divider: 40 ns, inside 18..100 ns
  localparam logic [5:0] WLA [8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
  localparam logic [5:0] WLB [8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
  localparam logic [5:0] RLA [8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
  localparam logic [5:0] RLB [8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
  localparam lp_pkg::lp_cmd_t PDC [2] = '{lp_pkg::LP_CMD_ZQS, lp_pkg::LP_CMD_MRW};
  logic i_mclk; // Core clock
  logic i_rst; // Synchronous reset
  logic i_boot; // Slow clock mode
  logic i_pd_req; // Power-down request
  logic i_req_valid; // Request strobe
  lp_pkg::lp_cmd_t i_req_cmd; // Request command
  logic [5:0] i_req_ma; // Request address
  logic [7:0] i_req_op; // Request operand
  logic [2:0] i_temp_rate; // Sensor rate
  logic o_req_ready;
  logic o_pd_active;
  logic o_rd_valid;
  logic [7:0] o_rd_data;
  logic [5:0] o_wl;
  logic [5:0] o_rl;
  logic [2:0] o_refresh_rate;
  logic o_pd;
  int bad_count; // Mismatches
  int num_checks; // Comparisons
  int cyc; // Cycles run, for the hang limit
  int ticks; // Device edges seen in boot mode
  logic [31:0] seed; // Random state
  logic [7:0] rv; // Random operand
  logic [7:0] exp_q [$]; // Expected read-back bytes, oldest first

  lp_link_if lp_link_if_i ();
  lp_ctrl_end #(.BOOT_DIV(BD)) lp_ctrl_end_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_boot(i_boot),
    .i_pd_req(i_pd_req), .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
    .i_req_ma(i_req_ma), .i_req_op(i_req_op), .o_req_ready(o_req_ready),
    .o_pd_active(o_pd_active), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
    .link(lp_link_if_i.ctrl));
  lp_dev_end lp_dev_end_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_temp_rate(i_temp_rate),
    .o_wl(o_wl), .o_rl(o_rl), .o_refresh_rate(o_refresh_rate), .o_pd(o_pd),
    .link(lp_link_if_i.dev));
  lp_link_sva lp_link_sva_i (.i_mclk(i_mclk), .i_rst(i_rst), .ck_tick(lp_link_if_i.ck_tick),
    .cke(lp_link_if_i.cke), .cs(lp_link_if_i.cs), .cs_drv(lp_link_if_i.cs_drv),
    .cmd(lp_link_if_i.cmd), .ma(lp_link_if_i.ma), .op(lp_link_if_i.op),
    .dqs_oe(lp_link_if_i.dqs_oe));

  // Free-running core clock
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Holds the request until ready is seen settled, so the next edge takes it
  // An edge passes first, so a drop and a raise of valid never share a time step
  task automatic send(input lp_pkg::lp_cmd_t c, input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1;
    i_req_valid = 1'b1;
    i_req_cmd = c;
    i_req_ma = a;
    i_req_op = d;
    while (o_req_ready !== 1'b1)
      @(posedge i_mclk) #1;
    @(posedge i_mclk) #1;
    i_req_valid = 1'b0;
  endtask

  // Each read result is matched against the oldest note
  always @(posedge i_mclk)
  begin
    #2;
    if (o_rd_valid === 1'b1)
      cmp(o_rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
  end

  // Hang limit, far above the expected run length
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    i_rst = 1'b1;
    i_boot = 1'b0;
    i_pd_req = 1'b0;
    i_req_valid = 1'b0;
    i_req_cmd = lp_pkg::LP_CMD_NOP;
    i_req_ma = 6'h00;
    i_req_op = 8'h00;
    i_temp_rate = 3'h0;
    seed = 32'h000135E2;
    repeat (5) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    // Every write latency code under both table choices, random read latency codes, back-to-back writes
    for (int k = 0; k < 16; k++)
    begin
      seed = xs(seed);
      send(lp_pkg::LP_CMD_MRW, 6'h02, {1'b0, k[3], k[2:0], seed[2:0]});
      send(lp_pkg::LP_CMD_MRW, 6'h03, {1'b0, k[3], 6'h00});
      repeat (12) @(posedge i_mclk);
      #1 cmp({2'h0, o_wl}, {2'h0, k[3] ? WLB[k[2:0]] : WLA[k[2:0]]});
      cmp({2'h0, o_rl}, {2'h0, k[3] ? RLB[seed[2:0]] : RLA[seed[2:0]]});
    end
    seed = xs(seed);
    rv = seed[7:0];
    send(lp_pkg::LP_CMD_MRW, 6'h10, rv);
    exp_q.push_back(rv);
    send(lp_pkg::LP_CMD_MRR, 6'h10, 8'h00);
    exp_q.push_back(8'h40);
    send(lp_pkg::LP_CMD_MRR, 6'h03, 8'h00);
    i_temp_rate = seed[10:8];
    repeat (3) @(posedge i_mclk);
    #1 cmp({5'h00, o_refresh_rate}, {5'h00, seed[10:8]});
    send(lp_pkg::LP_CMD_MRW, 6'h0F, 8'h01);
    repeat (14) @(posedge i_mclk);
    #1 cmp({7'h00, lp_link_if_i.dqs_oe}, 8'h01);
    // Power-down straight after calibration start and after a mode write
    foreach (PDC[i])
    begin
      send(PDC[i], 6'h0F, 8'h00);
      i_pd_req = 1'b1;
      repeat (30) @(posedge i_mclk);
      #1 cmp({5'h00, lp_link_if_i.ck_tick, o_pd, o_pd_active}, 8'h03);
      i_pd_req = 1'b0;
      exp_q.push_back({5'h00, i_temp_rate});
      send(lp_pkg::LP_CMD_MRR, 6'h04, 8'h00);
    end
    i_boot = 1'b1;
    repeat (8) @(posedge i_mclk);
    ticks = 0;
    repeat (40)
    begin
      @(posedge i_mclk) #1;
      ticks += int'(lp_link_if_i.ck_tick);
    end
    cmp(8'(ticks), 8'(40 / BD));
    i_boot = 1'b0;
    repeat (80) @(posedge i_mclk);
    cmp(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule
